// >>> hw/lss_pkg.sv
package lss_pkg;

  // Link framing
  localparam int          DATA_W      = 8;
  localparam int          CNT_W       = 3;
  localparam int          SYNC_STAGES = 3;
  localparam logic [2:0]  SETUP_LAST  = 3'h1;
  localparam logic [2:0]  DATA_LAST   = 3'h7;
  localparam logic        DIR_READ    = 1'b1;
  localparam logic        TGT_STATUS  = 1'b1;
  localparam logic        STAT_OK     = 1'b0;
  localparam logic        STAT_FAIL   = 1'b1;
  localparam logic        MISO_IDLE   = 1'b0;

  // Gray path: idle, setup, data, status, tail
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_DATA  = 3'b011,
    ST_STAT  = 3'b010,
    ST_TAIL  = 3'b110
  } link_state_e;

  // Serial status byte fields
  localparam int SB_RX_FULL_N = 0;
  localparam int SB_TX_EMPTY_N = 1;
  localparam int SB_RX_IRQ_EN = 4;
  localparam int SB_TX_IRQ_EN = 5;

  // Bus side
  localparam int          HADDR_W     = 32;
  localparam int          HDATA_W     = 32;
  localparam int          DEC_W       = 8;
  localparam logic [2:0]  SIZE_WORD   = 3'h2;
  localparam logic [7:0]  OFF_TX_DATA = 8'h00;
  localparam logic [7:0]  OFF_RX_DATA = 8'h04;
  localparam logic [7:0]  OFF_STATUS  = 8'h08;
  localparam logic [7:0]  OFF_CTRL    = 8'h0c;

  // Bus status register fields
  localparam int REG_RX_FULL  = 0;
  localparam int REG_TX_FULL  = 1;
  localparam int REG_BUSY     = 2;

  // Control register fields and reset
  localparam int          CTRL_RX_IRQ_EN = 0;
  localparam int          CTRL_TX_IRQ_EN = 1;
  localparam logic [1:0]  CTRL_RST       = 2'h0;

endpackage : lss_pkg

// >>> hw/pin_sync.sv
module pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output      logic [WIDTH-1:0] filt_out
);
  import lss_pkg::*;

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] filt_q;

  // First stage feeds only the second
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once stages two and three agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_filt
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        filt_q[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        filt_q[i] <= s3_q[i];
      end
    end
  end

  assign filt_out = filt_q;

endmodule : pin_sync

// >>> hw/legacy_serial_slave_12clk.sv
// Summary of operation
// - Select is active high; selected only while high
// - Decode read, status read, write, undefined
// - Status target: read returns status, write ignored
// - One byte per transaction, MSB first
// - Twelve clocks: start, setup, eight data, status
// - Mosi sampled and miso driven on rising clock
// - Start on select and mosi high; 13 edges
// - Data read shifts transmit byte then status
// - Read status 0 pops byte, 1 stale
// - Status bit valid until following rising edge
// - Write takes eight bits; status accept/drop
// - Write status driven on edge after data
// - Status read sends byte then zero bit
// - Status bits 0,1 flags; 2,3 zero; 4 enable
// - Status bit 5 enable; bits 6,7 zero
module legacy_serial_slave_12clk (
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  input  wire logic                        sclk,
  input  wire logic                        ss,
  input  wire logic                        mosi,
  output      logic                        miso,
  input  wire logic                        hsel,
  input  wire logic [lss_pkg::HADDR_W-1:0] haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [lss_pkg::HDATA_W-1:0] hwdata,
  input  wire logic                        hready,
  output      logic                        hreadyout,
  output      logic [lss_pkg::HDATA_W-1:0] hrdata,
  output      logic                        hresp
);
  import lss_pkg::*;

  logic [2:0]         filt;
  logic               sclk_f;
  logic               ss_f;
  logic               mosi_f;
  logic               sclk_prev_q;
  logic               sclk_rise;
  link_state_e        state_q;
  logic [CNT_W-1:0]   cnt_q;
  logic               dir_q;
  logic               tgt_q;
  logic [DATA_W-1:0]  shreg_q;
  logic               snap_valid_q;
  logic               miso_q;
  logic               stat_bit;
  logic               abort;
  logic               commit;
  logic [DATA_W-1:0]  status_byte;
  logic [DATA_W-1:0]  tx_data_q;
  logic               tx_valid_q;
  logic [DATA_W-1:0]  rx_data_q;
  logic               rx_full_q;
  logic [1:0]         ctrl_q;
  logic               acc;
  logic               wr_pend_q;
  logic [DEC_W-1:0]   wr_addr_q;
  logic               tx_wr;
  logic               rx_pop;
  logic [HDATA_W-1:0] rd_mux;
  logic               hreadyout_q;
  logic [HDATA_W-1:0] hrdata_q;
  logic               hresp_q;

  pin_sync #(
    .WIDTH    (3)
  ) u_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in ({sclk, ss, mosi}),
    .filt_out (filt)
  );

  assign sclk_f = filt[2];
  assign ss_f   = filt[1];
  assign mosi_f = filt[0];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_f;
    end
  end

  assign sclk_rise = sclk_f & ~sclk_prev_q;

  assign abort  = (state_q != ST_IDLE) && !ss_f;
  assign commit = sclk_rise && ss_f && (state_q == ST_STAT);

  always_comb begin
    status_byte = '0;
    status_byte[SB_RX_FULL_N]  = ~rx_full_q;
    status_byte[SB_TX_EMPTY_N] = tx_valid_q;
    status_byte[SB_RX_IRQ_EN]  = ctrl_q[CTRL_RX_IRQ_EN];
    status_byte[SB_TX_IRQ_EN]  = ctrl_q[CTRL_TX_IRQ_EN];
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      dir_q   <= 1'b0;
      tgt_q   <= 1'b0;
    end else if (abort) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
    end else if (sclk_rise) begin
      case (state_q)
        ST_IDLE: begin
          if (ss_f && mosi_f) begin
            state_q <= ST_SETUP;
            cnt_q   <= '0;
          end
        end
        ST_SETUP: begin
          if (cnt_q == SETUP_LAST) begin
            tgt_q   <= mosi_f;
            state_q <= ST_DATA;
            cnt_q   <= '0;
          end else begin
            dir_q <= mosi_f;
            cnt_q <= cnt_q + 3'h1;
          end
        end
        ST_DATA: begin
          if (cnt_q == DATA_LAST) begin
            state_q <= ST_STAT;
            cnt_q   <= '0;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        ST_STAT: begin
          state_q <= ST_TAIL;
        end
        ST_TAIL: begin
          if (ss_f && mosi_f) begin
            state_q <= ST_SETUP;
            cnt_q   <= '0;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // one shifter, MSB first both ways
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      shreg_q      <= '0;
      snap_valid_q <= 1'b0;
    end else if (sclk_rise && ss_f) begin
      if (state_q == ST_SETUP && cnt_q == SETUP_LAST) begin
        snap_valid_q <= tx_valid_q;
        if (dir_q != DIR_READ) begin
          shreg_q <= '0;
        end else if (mosi_f == TGT_STATUS) begin
          shreg_q <= status_byte;
        end else begin
          shreg_q <= tx_data_q;
        end
      end else if (state_q == ST_DATA) begin
        shreg_q <= {shreg_q[DATA_W-2:0], mosi_f};
      end
    end
  end

  always_comb begin
    case ({dir_q, tgt_q})
      2'b10:   stat_bit = snap_valid_q ? STAT_OK : STAT_FAIL;
      2'b11:   stat_bit = STAT_OK;
      2'b00:   stat_bit = rx_full_q ? STAT_FAIL : STAT_OK;
      default: stat_bit = STAT_FAIL;
    endcase
  end

  // data bits then status on miso
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      miso_q <= MISO_IDLE;
    end else if (abort) begin
      miso_q <= MISO_IDLE;
    end else if (sclk_rise) begin
      case (state_q)
        ST_DATA:  miso_q <= shreg_q[DATA_W-1];
        // status on edge after last bit
        ST_STAT:  miso_q <= stat_bit;
        // status gone on the next edge
        default:  miso_q <= MISO_IDLE;
      endcase
    end
  end

  assign miso = miso_q;

  // accept into receive buffer unless full
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_data_q <= '0;
      rx_full_q <= 1'b0;
    end else if (commit && dir_q != DIR_READ && tgt_q != TGT_STATUS && !rx_full_q) begin
      rx_data_q <= shreg_q;
      rx_full_q <= 1'b1;
    end else if (rx_pop) begin
      rx_full_q <= 1'b0;
    end
  end

  // pop only when a new byte was sent
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_data_q  <= '0;
      tx_valid_q <= 1'b0;
    end else if (tx_wr && !tx_valid_q) begin
      tx_data_q  <= hwdata[DATA_W-1:0];
      tx_valid_q <= 1'b1;
    end else if (commit && dir_q == DIR_READ && tgt_q != TGT_STATUS && snap_valid_q) begin
      tx_valid_q <= 1'b0;
    end
  end

  // Bus slave: zero wait states, always OKAY
  assign acc    = hsel && htrans[1] && hready;
  assign rx_pop = acc && !hwrite && (haddr[DEC_W-1:0] == OFF_RX_DATA);
  assign tx_wr  = wr_pend_q && (wr_addr_q == OFF_TX_DATA);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= acc && hwrite && (hsize == SIZE_WORD);
      wr_addr_q <= haddr[DEC_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_pend_q && wr_addr_q == OFF_CTRL) begin
      ctrl_q <= hwdata[1:0];
    end
  end

  // Unmapped offsets read as zero
  always_comb begin
    rd_mux = '0;
    if (haddr[DEC_W-1:0] == OFF_TX_DATA) begin
      rd_mux[DATA_W-1:0] = tx_data_q;
    end else if (haddr[DEC_W-1:0] == OFF_RX_DATA) begin
      rd_mux[DATA_W-1:0] = rx_data_q;
    end else if (haddr[DEC_W-1:0] == OFF_STATUS) begin
      rd_mux[REG_RX_FULL] = rx_full_q;
      rd_mux[REG_TX_FULL] = tx_valid_q;
      rd_mux[REG_BUSY]    = (state_q != ST_IDLE);
    end else if (haddr[DEC_W-1:0] == OFF_CTRL) begin
      rd_mux[1:0] = ctrl_q;
    end
  end

  // Read data captured in the address phase
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hrdata_q    <= '0;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      if (acc && !hwrite) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata    = hrdata_q;
  assign hresp     = hresp_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_start;
    state_q == ST_IDLE && sclk_rise && ss_f && mosi_f |=> state_q == ST_SETUP;
  endproperty
  a_start: assert property (p_start)
    else $error("start not taken");
  property p_deselect;
    abort |=> state_q == ST_IDLE && miso_q == MISO_IDLE;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("deselect did not end transfer");
  property p_byte_len;
    state_q == ST_DATA && cnt_q == DATA_LAST && sclk_rise && ss_f |=> state_q == ST_STAT;
  endproperty
  a_byte_len: assert property (p_byte_len)
    else $error("data phase length wrong");
  property p_status_zero;
    commit && dir_q == DIR_READ && tgt_q == TGT_STATUS |=> miso_q == STAT_OK;
  endproperty
  a_status_zero: assert property (p_status_zero)
    else $error("status read trailer not zero");
  property p_undefined;
    commit && dir_q != DIR_READ && tgt_q == TGT_STATUS
      |=> miso_q == STAT_FAIL && $stable(rx_full_q) && $stable(rx_data_q);
  endproperty
  a_undefined: assert property (p_undefined)
    else $error("undefined command had an effect");
  property p_write_ok;
    commit && dir_q != DIR_READ && tgt_q != TGT_STATUS && !rx_full_q
      |=> rx_full_q && rx_data_q == $past(shreg_q) && miso_q == STAT_OK;
  endproperty
  a_write_ok: assert property (p_write_ok)
    else $error("write not accepted");
  property p_write_drop;
    commit && dir_q != DIR_READ && tgt_q != TGT_STATUS && rx_full_q
      |=> $stable(rx_data_q) && miso_q == STAT_FAIL;
  endproperty
  a_write_drop: assert property (p_write_drop)
    else $error("full buffer write not rejected");
  property p_read_pop;
    commit && dir_q == DIR_READ && tgt_q != TGT_STATUS
      |=> miso_q == !$past(snap_valid_q) && (!$past(snap_valid_q) || !tx_valid_q);
  endproperty
  a_read_pop: assert property (p_read_pop)
    else $error("read status or pop wrong");
  property p_status_hold;
    state_q == ST_TAIL && sclk_rise ##1 !sclk_rise [*2] |-> miso_q == MISO_IDLE;
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("status bit held too long");
  c_write: cover property (commit && dir_q != DIR_READ && tgt_q != TGT_STATUS && !rx_full_q);
  c_read_new: cover property (commit && dir_q == DIR_READ && tgt_q != TGT_STATUS && snap_valid_q);
  c_status: cover property (commit && dir_q == DIR_READ && tgt_q == TGT_STATUS);
  c_abort: cover property (abort && state_q == ST_DATA);

endmodule : legacy_serial_slave_12clk

// >>> test/serial_master_model.sv
module serial_master_model (
  output logic      sclk,
  output logic      ss,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;

  // Clock stands still low between frames
  initial begin
    sclk = 1'b0;
    ss   = 1'b0;
    mosi = 1'b0;
  end

  task automatic xfer(input logic dir, input logic tgt, input logic [7:0] wd,
                      input int cut, input logic hold, output logic [7:0] rd,
                      output logic stat);
    logic [12:0] bits;
    bits = {1'b1, dir, tgt, wd, 2'b00};
    for (int e = 0; e < 13; e++) begin
      ss   = (e < cut);
      mosi = bits[12-e];
      #100 sclk = 1'b1;
      if (e >= 4 && e <= 11)
        rd[11-e] = miso;
      if (e == 12)
        stat = miso;
      #100 sclk = 1'b0;
    end
    if (!hold) begin
      ss   = 1'b0;
      mosi = ~mosi;
      #200;
    end
  endtask : xfer
endmodule : serial_master_model

// >>> test/legacy_serial_slave_12clk_bench.sv
`define CHK(what, exp, got) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); \
  end \
end

module legacy_serial_slave_12clk_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import lss_pkg::*;

  logic               clock, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
  logic               sclk, ss, mosi, miso, stat;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [HADDR_W-1:0] haddr;
  logic [HDATA_W-1:0] hwdata, hrdata, rd;
  logic [7:0]         sb;
  int                 fail_count = 0;
  int                 checks = 0;

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  legacy_serial_slave_12clk legacy_serial_slave_12clk_inst (
    .clock(clock), .sys_rst(sys_rst), .sclk(sclk), .ss(ss), .mosi(mosi), .miso(miso),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp));

  serial_master_model serial_master_model_inst (
    .sclk(sclk), .ss(ss), .mosi(mosi), .miso(miso));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      finish_test();
    end
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= SIZE_WORD;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : bus

  task automatic ser(input logic dir, input logic tgt, input logic [7:0] wd,
                     input int cut, input logic hold);
    // Odd offset keeps link edges off the clock grid
    #7;
    serial_master_model_inst.xfer(dir, tgt, wd, cut, hold, sb, stat);
    if (!hold)
      `CHK("miso idle", MISO_IDLE, miso)
  endtask : ser

  task automatic t_reset;
    `CHK("miso", MISO_IDLE, miso)
    bus(1'b0, OFF_STATUS, 32'h0);
    `CHK("status reg", 32'h0, rd)
    bus(1'b0, OFF_CTRL, 32'h0);
    `CHK("ctrl reg", 32'h0, rd)
    bus(1'b1, 8'h10, 32'hff);
    bus(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h0, rd)
  endtask : t_reset

  task automatic t_status;
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, OFF_CTRL, 32'(c));
      ser(1'b1, 1'b1, 8'h0, 13, c < 3);
      `CHK("status byte", {2'b00, 2'(c), 3'b000, 1'b1}, sb)
      `CHK("status trailer", STAT_OK, stat)
    end
  endtask : t_status

  task automatic t_read;
    bus(1'b1, OFF_TX_DATA, 32'h96);
    bus(1'b1, OFF_TX_DATA, 32'h5a);
    bus(1'b0, OFF_STATUS, 32'h0);
    `CHK("tx pending", 32'h2, rd)
    ser(1'b1, 1'b1, 8'h0, 13, 1'b0);
    `CHK("status byte", 8'h33, sb)
    ser(1'b1, 1'b0, 8'h0, 13, 1'b0);
    `CHK("read byte", 8'h96, sb)
    `CHK("read stat", STAT_OK, stat)
    ser(1'b1, 1'b0, 8'h0, 13, 1'b0);
    `CHK("stale byte", 8'h96, sb)
    `CHK("stale stat", STAT_FAIL, stat)
    bus(1'b1, OFF_TX_DATA, 32'h3b);
    ser(1'b1, 1'b0, 8'h0, 13, 1'b0);
    `CHK("retry byte", 8'h3b, sb)
    `CHK("retry stat", STAT_OK, stat)
  endtask : t_read

  task automatic t_write;
    ser(1'b0, 1'b0, 8'hc5, 13, 1'b0);
    `CHK("write stat", STAT_OK, stat)
    ser(1'b0, 1'b0, 8'h81, 13, 1'b0);
    `CHK("full stat", STAT_FAIL, stat)
    ser(1'b1, 1'b1, 8'h0, 13, 1'b0);
    `CHK("status byte", 8'h30, sb)
    bus(1'b0, OFF_RX_DATA, 32'h0);
    `CHK("rx byte", 32'hc5, rd)
    ser(1'b0, 1'b0, 8'h81, 13, 1'b0);
    `CHK("resend stat", STAT_OK, stat)
    bus(1'b0, OFF_RX_DATA, 32'h0);
    `CHK("rx byte", 32'h81, rd)
  endtask : t_write

  task automatic t_odd;
    int cuts[3] = '{0, 6, 11};
    ser(1'b0, 1'b1, 8'h55, 13, 1'b0);
    `CHK("undef stat", STAT_FAIL, stat)
    // Select lost before or inside the frame
    foreach (cuts[i])
      ser(1'b0, 1'b0, 8'h77, cuts[i], 1'b0);
    bus(1'b0, OFF_STATUS, 32'h0);
    `CHK("no change", 32'h0, rd)
  endtask : t_odd

  initial begin
    sys_rst = 1'b1;
    hsel    = 1'b0;
    haddr   = '0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = SIZE_WORD;
    hwdata  = '0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_status();
    t_read();
    t_write();
    t_odd();
    finish_test();
  end
endmodule : legacy_serial_slave_12clk_bench
